// *** core/fcg_pkg.sv ***
// package for the clock generator configuration block
// assumes an apb slave with 32-bit data; offsets below are byte addresses
// Notes on behaviour
// RULE_01: reset starts self-clocked, output about 8 MHz
// RULE_02: internal engaged: ref/7 times 64 times N/R
// RULE_03: scheme field 4:3 code 01 engages internal
// RULE_04: range bit 6 low: low range, P=64
// RULE_05: gain bit 7 low: low-power oscillator
// RULE_06: bit 5 requests crystal; ignored in internal
// RULE_07: control one bit 0 reads zero
// RULE_08: lock-loss response low: lock loss interrupts
// RULE_09: clock-loss response low: clock loss interrupts
// RULE_10: multiplier field 6:4 code 011 gives 10
// RULE_11: divisor field 2:0 code 001 divides two
// RULE_12: status one read-only; write clears flag
// RULE_13: status two read-only; software checks it
// RULE_14: trim 7:0 adjusts internal oscillator
// RULE_15: software trims with doubled divisor near maximum
// RULE_16: multiplier codes map to 4 through 18
// RULE_17: divisor codes map to 1 through 128
// RULE_18: scheme 11 engages external: ext*P*N/R
// RULE_19: range bit high: high range, P=1
// RULE_20: bus clock is generator output halved
package fcg_pkg;
   localparam logic [7:0] FCG_OFS_CTRL1 = 8'h00;
   localparam logic [7:0] FCG_OFS_CTRL2 = 8'h04;
   localparam logic [7:0] FCG_OFS_STAT1 = 8'h08;
   localparam logic [7:0] FCG_OFS_STAT2 = 8'h0c;
   localparam logic [7:0] FCG_OFS_TRIM = 8'h10;
   localparam logic [7:0] FCG_OFS_FREQ = 8'h14;
   localparam logic [7:0] FCG_CTRL1_RST = 8'h00;
   localparam logic [7:0] FCG_CTRL2_RST = 8'h00;
   localparam logic [7:0] FCG_TRIM_RST = 8'h80;
   localparam int FCG_B_GAIN = 7;
   localparam int FCG_B_RANGE = 6;
   localparam int FCG_B_REFSEL = 5;
   localparam int FCG_B_SCH_HI = 4;
   localparam int FCG_B_SCH_LO = 3;
   localparam int FCG_B_OSCKEEP = 2;
   localparam int FCG_B_LOCDIS = 1;
   localparam int FCG_B_LOLRESP = 7;
   localparam int FCG_B_MUL_HI = 6;
   localparam int FCG_B_MUL_LO = 4;
   localparam int FCG_B_LOCRESP = 3;
   localparam int FCG_B_DIV_HI = 2;
   localparam int FCG_B_DIV_LO = 0;
   // status one layout
   localparam int FCG_S1_IRQ = 0;
   localparam int FCG_S1_LOCK = 3;
   localparam int FCG_S1_LOCS = 2;
   localparam int FCG_S1_LOLS = 1;
   localparam int FCG_S1_ERCS = 4;
   localparam int FCG_S1_SCH_LO = 6;
   // status two layout
   localparam int FCG_S2_DCOS = 0;
   localparam logic [6:0] FCG_PRE_LOW = 7'd64;
   localparam logic [6:0] FCG_PRE_HIGH = 7'd1;
   localparam logic [3:0] FCG_IRG_DIV = 4'd7;
   localparam int FCG_SCM_KHZ = 8000;
   localparam int FCG_IRG_KHZ = 243;
   typedef enum logic [1:0] {
      FCG_SCM = 2'b00, FCG_FBE = 2'b10,
      FCG_FEI = 2'b01, FCG_FEE = 2'b11
   } fcg_scheme_t;
endpackage

// *** core/fcg_top.sv ***
// clock generator configuration: registers, factor decode, status, requests
// assumes apb master in mclk_in domain; loop status inputs are synchronous
`timescale 1ns/1ps
module fcg_top
   import fcg_pkg::*;
#(
   parameter int EXT_KHZ = 32
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   // apb
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // analog loop status
   input wire logic lock_in,
   input wire logic ref_ok_in,
   input wire logic dco_stable_in,
   // generator control
   output logic [1:0] scheme_out,
   output logic osc_req_out,
   output logic high_gain_out,
   output logic high_range_out,
   output logic [6:0] prescale_out,
   output logic [4:0] mult_out,
   output logic [7:0] div_out,
   output logic [7:0] trim_out,
   output logic [31:0] out_khz_out,
   output logic [31:0] bus_khz_out,
   output logic irq_out
);
   typedef struct packed {
      logic [7:0] c1;
      logic [7:0] c2;
      logic [7:0] trim;
      logic lol_f;
      logic loc_f;
      logic irq_f;
      logic lock_d;
      logic ref_d;
      logic [31:0] rdata;
      logic [31:0] khz;
   } fcg_state_t;
   fcg_state_t s_r, s_nxt;

   // every check below lives in the mclk_in domain and sleeps in reset
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (reset_in);

   // decode multiplier code to N
   function automatic logic [4:0] mul_n(input logic [2:0] c);
      return 5'(({2'b00, c} << 1) + 5'd4); // [RULE_16] [RULE_10]
   endfunction
   // decode divisor code to R
   function automatic logic [7:0] div_r(input logic [2:0] c);
      return 8'(8'h01 << c); // [RULE_17] [RULE_11]
   endfunction

   logic wr, rd;
   logic [1:0] sch;
   logic [6:0] pre;
   logic [4:0] n;
   logic [7:0] r;
   logic [7:0] s1, s2;
   assign wr = psel_in & penable_in & pwrite_in & clk_en_in;
   assign rd = psel_in & penable_in & ~pwrite_in & clk_en_in;
   assign sch = s_r.c1[FCG_B_SCH_HI:FCG_B_SCH_LO];
   assign pre = s_r.c1[FCG_B_RANGE] ? FCG_PRE_HIGH
                                    : FCG_PRE_LOW; // [RULE_04] [RULE_19]
   assign n = mul_n(s_r.c2[FCG_B_MUL_HI:FCG_B_MUL_LO]);
   assign r = div_r(s_r.c2[FCG_B_DIV_HI:FCG_B_DIV_LO]);

   always_comb begin
      s1 = 8'h00;
      s1[FCG_S1_IRQ] = s_r.irq_f;
      s1[FCG_S1_LOLS] = s_r.lol_f;
      s1[FCG_S1_LOCS] = s_r.loc_f;
      s1[FCG_S1_LOCK] = lock_in;
      s1[FCG_S1_ERCS] = ref_ok_in;
      s1[FCG_S1_SCH_LO +: 2] = sch;
      s2 = 8'h00;
      s2[FCG_S2_DCOS] = dco_stable_in; // [RULE_13]
   end

   always_comb begin
      logic lol_ev;
      logic loc_ev;
      s_nxt = s_r;
      lol_ev = s_r.lock_d & ~lock_in & sch[0];
      loc_ev = s_r.ref_d & ~ref_ok_in & ~s_r.c1[FCG_B_LOCDIS] & sch[1];
      s_nxt.lock_d = lock_in;
      s_nxt.ref_d = ref_ok_in;
      if (wr) begin
         case (paddr_in)
            // bit 0 not stored so it reads zero
            FCG_OFS_CTRL1: s_nxt.c1 = {pwdata_in[7:1], 1'b0}; // [RULE_07]
            FCG_OFS_CTRL2: s_nxt.c2 = pwdata_in[7:0];
            FCG_OFS_TRIM: s_nxt.trim = pwdata_in[7:0]; // [RULE_14]
            // any write clears the request flag; set below still wins
            FCG_OFS_STAT1: begin
               s_nxt.irq_f = 1'b0; // [RULE_12]
               s_nxt.lol_f = 1'b0;
               s_nxt.loc_f = 1'b0;
            end
            default: ;
         endcase
      end
      if (lol_ev) begin
         s_nxt.lol_f = 1'b1;
         if (!s_r.c2[FCG_B_LOLRESP]) s_nxt.irq_f = 1'b1; // [RULE_08]
      end
      if (loc_ev) begin
         s_nxt.loc_f = 1'b1;
         if (!s_r.c2[FCG_B_LOCRESP]) s_nxt.irq_f = 1'b1; // [RULE_09]
      end
      case (paddr_in)
         FCG_OFS_CTRL1: s_nxt.rdata = {24'h0, s_r.c1};
         FCG_OFS_CTRL2: s_nxt.rdata = {24'h0, s_r.c2};
         FCG_OFS_STAT1: s_nxt.rdata = {24'h0, s1};
         FCG_OFS_STAT2: s_nxt.rdata = {24'h0, s2};
         FCG_OFS_TRIM: s_nxt.rdata = {24'h0, s_r.trim};
         FCG_OFS_FREQ: s_nxt.rdata = s_r.khz;
         default: s_nxt.rdata = 32'h0;
      endcase
      case (fcg_scheme_t'(sch))
         FCG_SCM: s_nxt.khz = 32'(FCG_SCM_KHZ) / 32'(r); // [RULE_01]
         FCG_FBE: s_nxt.khz = 32'(EXT_KHZ) / 32'(r);
         // reference select is ignored here by design [RULE_06]
         // prescale fixed at the low value, not the range bit [RULE_03]
         FCG_FEI: s_nxt.khz = 32'(FCG_IRG_KHZ) * 32'(FCG_PRE_LOW)
                  * 32'(n) / 32'(FCG_IRG_DIV) / 32'(r); // [RULE_02]
         FCG_FEE: s_nxt.khz = 32'(EXT_KHZ) * 32'(pre)
                  * 32'(n) / 32'(r); // [RULE_18]
         default: s_nxt.khz = 32'(FCG_SCM_KHZ);
      endcase
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         s_r <= '0;
         s_r.c1 <= FCG_CTRL1_RST; // [RULE_01]
         s_r.c2 <= FCG_CTRL2_RST;
         s_r.trim <= FCG_TRIM_RST;
         s_r.khz <= 32'(FCG_SCM_KHZ);
      end else if (clk_en_in) begin
         s_r <= s_nxt;
      end
   end

   assign pready_out = 1'b1;
   assign pslverr_out = 1'b0;
   // read data registered in setup; zero-wait access returns it
   assign prdata_out = s_r.rdata;
   assign scheme_out = sch;
   assign osc_req_out = s_r.c1[FCG_B_REFSEL] & sch[1]; // [RULE_06]
   assign high_gain_out = s_r.c1[FCG_B_GAIN]; // [RULE_05]
   assign high_range_out = s_r.c1[FCG_B_RANGE];
   assign prescale_out = pre;
   assign mult_out = n;
   assign div_out = r;
   assign trim_out = s_r.trim;
   assign out_khz_out = s_r.khz;
   assign bus_khz_out = s_r.khz >> 1; // [RULE_20]
   assign irq_out = s_r.irq_f;

   // factor decode: table points checked against fixed numbers
   AST_DIV_TWO: assert property ( // [RULE_11]
      s_r.c2[FCG_B_DIV_HI:FCG_B_DIV_LO] == 3'b001 |-> div_out == 8'd2)
      else $error("divisor code 001 not two");

   AST_MUL_TEN: assert property ( // [RULE_10]
      s_r.c2[FCG_B_MUL_HI:FCG_B_MUL_LO] == 3'b011 |-> mult_out == 5'd10)
      else $error("multiplier code 011 not ten");

   AST_MUL_MIN: assert property ( // [RULE_16]
      s_r.c2[FCG_B_MUL_HI:FCG_B_MUL_LO] == 3'b000 |-> mult_out == 5'd4)
      else $error("multiplier code 000 not four");

   AST_MUL_SIX: assert property ( // [RULE_16]
      s_r.c2[FCG_B_MUL_HI:FCG_B_MUL_LO] == 3'b001 |-> mult_out == 5'd6)
      else $error("multiplier code 001 not six");

   AST_MUL_MAX: assert property ( // [RULE_16]
      s_r.c2[FCG_B_MUL_HI:FCG_B_MUL_LO] == 3'b111 |-> mult_out == 5'd18)
      else $error("multiplier code 111 not eighteen");

   AST_DIV_ONE: assert property ( // [RULE_17]
      s_r.c2[FCG_B_DIV_HI:FCG_B_DIV_LO] == 3'b000 |-> div_out == 8'd1)
      else $error("divisor code 000 not one");

   AST_DIV_FOUR: assert property ( // [RULE_17]
      s_r.c2[FCG_B_DIV_HI:FCG_B_DIV_LO] == 3'b010 |-> div_out == 8'd4)
      else $error("divisor code 010 not four");

   AST_DIV_MAX: assert property ( // [RULE_17]
      s_r.c2[FCG_B_DIV_HI:FCG_B_DIV_LO] == 3'b111 |-> div_out == 8'd128)
      else $error("divisor code 111 not 128");

   AST_PRE: assert property ( // [RULE_04]
      prescale_out == (high_range_out ? 7'd1 : 7'd64))
      else $error("prescale wrong for range");

   AST_PRE_HI: assert property ( // [RULE_19]
      high_range_out |-> prescale_out == 7'd1)
      else $error("high range prescale not one");

   AST_RANGE: assert property ( // [RULE_19]
      high_range_out == s_r.c1[FCG_B_RANGE])
      else $error("range output not from control one");

   AST_GAIN: assert property ( // [RULE_05]
      high_gain_out == s_r.c1[FCG_B_GAIN])
      else $error("gain output not from control one");

   AST_SCH: assert property ( // [RULE_03]
      wr && paddr_in == FCG_OFS_CTRL1 |=>
      scheme_out == $past(pwdata_in[FCG_B_SCH_HI:FCG_B_SCH_LO]))
      else $error("scheme field not taken from write");

   AST_OSC_FEI: assert property ( // [RULE_06]
      scheme_out == 2'b01 |-> !osc_req_out)
      else $error("crystal requested in internal engaged");

   // register side: write effects and read-only areas
   AST_BIT0: assert property ( // [RULE_07]
      !s_r.c1[0])
      else $error("control one bit 0 set");

   AST_C1_WR: assert property ( // [RULE_07]
      wr && paddr_in == FCG_OFS_CTRL1 |=>
      s_r.c1[7:1] == $past(pwdata_in[7:1]))
      else $error("control one write lost");

   AST_C2_WR: assert property (
      wr && paddr_in == FCG_OFS_CTRL2 |=> s_r.c2 == $past(pwdata_in[7:0]))
      else $error("control two write lost");

   AST_TRIM: assert property ( // [RULE_14]
      wr && paddr_in == FCG_OFS_TRIM |=> trim_out == $past(pwdata_in[7:0]))
      else $error("trim write lost");

   AST_S2_RO: assert property ( // [RULE_13]
      wr && paddr_in == FCG_OFS_STAT2 |=>
      $stable(s_r.c1) && $stable(s_r.c2) && $stable(s_r.trim))
      else $error("status two write changed a register");

   AST_PSLV: assert property (
      pready_out && !pslverr_out)
      else $error("slave stalled or flagged an error");

   // a low enable must hold every flop, flags included
   AST_FROZEN: assert property (
      !clk_en_in |=> $stable(s_r))
      else $error("state moved while clock enable low");

   // frequency model, one cycle behind the configuration
   AST_HALF: assert property ( // [RULE_20]
      bus_khz_out * 2 + {31'h0, out_khz_out[0]} == out_khz_out)
      else $error("bus clock not half");

   AST_SCM: assert property ( // [RULE_01]
      clk_en_in && sch == 2'b00 |=>
      out_khz_out == 32'(FCG_SCM_KHZ) / 32'($past(r)))
      else $error("self-clocked frequency wrong");

   AST_FBE: assert property (
      clk_en_in && sch == 2'b10 |=>
      out_khz_out == 32'(EXT_KHZ) / 32'($past(r)))
      else $error("bypassed external frequency wrong");

   AST_FEI: assert property ( // [RULE_02]
      clk_en_in && sch == 2'b01 && $stable(s_r.c2) |=> out_khz_out ==
      32'(FCG_IRG_KHZ) * 32'd64 * 32'($past(n)) / 32'd7
      / 32'($past(r)))
      else $error("internal engaged frequency wrong");

   AST_FEE: assert property ( // [RULE_18]
      clk_en_in && sch == 2'b11 |=> out_khz_out == 32'(EXT_KHZ)
      * 32'($past(pre)) * 32'($past(n)) / 32'($past(r)))
      else $error("external engaged frequency wrong");

   // loss events, flags and requests
   AST_LOL: assert property ( // [RULE_08]
      clk_en_in && s_r.lock_d && !lock_in && sch[0]
      && !s_r.c2[FCG_B_LOLRESP] |=> irq_out)
      else $error("lock loss raised no request");

   AST_LOL_FLAG: assert property ( // [RULE_08]
      clk_en_in && s_r.lock_d && !lock_in && sch[0] |=> s_r.lol_f)
      else $error("lock loss not flagged");

   AST_LOC: assert property ( // [RULE_09]
      clk_en_in && s_r.ref_d && !ref_ok_in && sch[1]
      && !s_r.c1[FCG_B_LOCDIS] && !s_r.c2[FCG_B_LOCRESP] |=> irq_out)
      else $error("clock loss raised no request");

   AST_LOC_FLAG: assert property ( // [RULE_09]
      clk_en_in && s_r.ref_d && !ref_ok_in && sch[1]
      && !s_r.c1[FCG_B_LOCDIS] |=> s_r.loc_f)
      else $error("clock loss not flagged");

   // detection switched off must never flag a clock loss
   AST_LOCDIS: assert property (
      clk_en_in && s_r.c1[FCG_B_LOCDIS] && !s_r.loc_f |=> !s_r.loc_f)
      else $error("clock loss flagged while detection off");

   AST_CLR: assert property ( // [RULE_12]
      wr && paddr_in == FCG_OFS_STAT1 && !(s_r.lock_d && !lock_in)
      && !(s_r.ref_d && !ref_ok_in) |=> !irq_out)
      else $error("status write did not clear");

   COV_FEI: cover property (sch == 2'b01);
   COV_FEE: cover property (sch == 2'b11);
   COV_IRQ: cover property ($rose(irq_out));
   COV_LOC: cover property ($rose(s_r.loc_f));
   COV_CLR: cover property (wr && paddr_in == FCG_OFS_STAT1 && irq_out);
endmodule // fcg_top

// *** verification/fcg_loop_model.sv ***
// far-side model: loop and reference status seen by the generator config
// assumes the bench commands loss events; single clock domain
`timescale 1ns/1ps
module fcg_loop_model #(
   parameter int LOCK_CYC = 6
) (
   input wire logic mclk_in,
   input wire logic [1:0] scheme_in,
   input wire logic drop_lock_in,
   input wire logic drop_ref_in,
   output logic lock_out,
   output logic ref_ok_out,
   output logic dco_stable_out
);
   int cnt = 0;
   // lock only after settling, so software has to poll status two
   always @(posedge mclk_in) begin
      if (!scheme_in[0] || drop_lock_in)
         cnt <= 0;
      else if (cnt < LOCK_CYC)
         cnt <= cnt + 1;
   end
   assign lock_out = (cnt == LOCK_CYC);
   assign dco_stable_out = lock_out;
   assign ref_ok_out = !drop_ref_in;
endmodule // fcg_loop_model

// *** verification/fll_clock_generator_config_test.sv ***
// testbench for the clock generator configuration block
// assumes zero-wait apb slave and the loop model on the status inputs
`timescale 1ns/1ps
module fll_clock_generator_config_test;
   import fcg_pkg::*;
   typedef struct packed {
      logic [7:0] c1, c2;
      logic [1:0] sch;
      logic osc, gain, rng;
      logic [6:0] pre;
      logic [4:0] n;
      logic [7:0] r;
   } fcg_row_t;
   logic mclk_in = 0, reset_in = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0, div, trim;
   logic [31:0] pwdata = 0, prdata, rd, okhz, bkhz;
   logic pready, drop_lock = 0, drop_ref = 0, lock, ref_ok, dco, osc;
   logic gain, rng, irq, slverr;
   logic [1:0] sch;
   logic [6:0] pre;
   logic [4:0] mult;
   int error_cnt = 0, n_compared = 0, k;
   fcg_row_t rows[8] = '{
      '{8'h38, 8'h00, 2'h3, 1'h1, 1'h0, 1'h0, 7'h40, 5'h04, 8'h01},
      '{8'h28, 8'h11, 2'h1, 1'h0, 1'h0, 1'h0, 7'h40, 5'h06, 8'h02},
      '{8'h78, 8'h22, 2'h3, 1'h1, 1'h0, 1'h1, 7'h01, 5'h08, 8'h04},
      '{8'h28, 8'h36, 2'h1, 1'h0, 1'h0, 1'h0, 7'h40, 5'h0a, 8'h40},
      '{8'h80, 8'h43, 2'h0, 1'h0, 1'h1, 1'h0, 7'h40, 5'h0c, 8'h08},
      '{8'h30, 8'h54, 2'h2, 1'h1, 1'h0, 1'h0, 7'h40, 5'h0e, 8'h10},
      '{8'hc8, 8'h65, 2'h1, 1'h0, 1'h1, 1'h1, 7'h01, 5'h10, 8'h20},
      '{8'h20, 8'h77, 2'h0, 1'h0, 1'h0, 1'h0, 7'h40, 5'h12, 8'h80}};
   fcg_top #(.EXT_KHZ(32)) DUT (.mclk_in(mclk_in), .reset_in(reset_in),
      .clk_en_in(1'b1), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(slverr),
      .lock_in(lock), .ref_ok_in(ref_ok), .dco_stable_in(dco),
      .scheme_out(sch), .osc_req_out(osc), .high_gain_out(gain),
      .high_range_out(rng), .prescale_out(pre), .mult_out(mult),
      .div_out(div), .trim_out(trim), .out_khz_out(okhz),
      .bus_khz_out(bkhz), .irq_out(irq));
   fcg_loop_model LM (.mclk_in(mclk_in), .scheme_in(sch),
      .drop_lock_in(drop_lock), .drop_ref_in(drop_ref), .lock_out(lock),
      .ref_ok_out(ref_ok), .dco_stable_out(dco));
   initial begin
      forever #2 mclk_in = ~mclk_in;
   end
   task finish_test;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] got, exp, input string m);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // one edge passes first so a strobe is never reassigned in one step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int j;
      @(posedge mclk_in);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk_in);
      penable <= 1;
      j = 0;
      do begin
         @(posedge mclk_in);
         j++;
      end while (pready !== 1'b1 && j < 50);
      rd = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e, input string m);
      apb(0, a, 0);
      chk(rd, e, m);
      chk(32'(slverr), 32'h0, "error response");
   endtask
   task settle(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   initial begin
      #200000;
      error_cnt++;
      finish_test;
   end
   initial begin
      settle(20);
      reset_in <= 0;
      chk({okhz, bkhz[15:0]} >> 16, 32'd8000, "reset freq");
      chk(bkhz, 32'd4000, "reset bus");
      rchk(FCG_OFS_CTRL1, 32'(FCG_CTRL1_RST), "c1 reset");
      rchk(FCG_OFS_CTRL2, 32'(FCG_CTRL2_RST), "c2 reset");
      rchk(FCG_OFS_TRIM, 32'(FCG_TRIM_RST), "trim reset");
      $display("reset test done");
      foreach (rows[i]) begin
         fcg_row_t e;
         e = rows[i];
         apb(1, FCG_OFS_CTRL1, 32'(e.c1));
         apb(1, FCG_OFS_CTRL2, 32'(e.c2));
         rchk(FCG_OFS_CTRL2, 32'(e.c2), "c2 back");
         chk(32'({sch, osc}), 32'({e.sch, e.osc}), "scheme");
         chk(32'(gain), 32'(e.gain), "gain");
         chk(32'(rng), 32'(e.rng), "rng");
         chk(32'(pre), 32'(e.pre), "pre");
         chk(32'(mult), 32'(e.n), "mult");
         chk(32'(div), 32'(e.r), "div");
      end
      $display("decode table done");
      apb(1, FCG_OFS_CTRL1, 32'h0000_00ff);
      rchk(FCG_OFS_CTRL1, 32'h0000_00fe, "c1 bit0");
      apb(1, FCG_OFS_TRIM, 32'h0000_005a);
      rchk(FCG_OFS_TRIM, 32'h0000_005a, "trim");
      chk(32'(trim), 32'h0000_005a, "trim out");
      rchk(8'h18, 32'h0, "unmapped");
      apb(1, FCG_OFS_CTRL1, 32'h0000_0038);
      apb(1, FCG_OFS_CTRL2, 32'h0000_0000);
      settle(2);
      chk(okhz, 32'd8192, "engaged ext freq");
      chk(bkhz, 32'd4096, "engaged ext bus");
      rchk(FCG_OFS_FREQ, 32'd8192, "freq reg");
      $display("register test done");
      apb(1, FCG_OFS_CTRL1, 32'h0000_0028);
      // trim at twice the final divisor, then restore it
      apb(1, FCG_OFS_CTRL2, 32'h0000_0032);
      apb(1, FCG_OFS_TRIM, 32'h0000_0060);
      apb(1, FCG_OFS_CTRL2, 32'h0000_0031);
      settle(2);
      chk(32'(trim), 32'h0000_0060, "trim kept");
      chk(okhz, 32'd11108, "engaged int freq");
      chk(bkhz, 32'd5554, "engaged int bus");
      for (int m = 0; m < 2; m++) begin
         apb(1, FCG_OFS_CTRL2, m ? 32'h0000_00b1 : 32'h0000_0031);
         k = 0;
         while (lock !== 1'b1 && k < 40) begin
            settle(1);
            k++;
         end
         apb(1, FCG_OFS_STAT2, 32'h0000_00fe);
         rchk(FCG_OFS_STAT2, 32'h1, "dco status");
         apb(1, FCG_OFS_STAT1, 32'h0);
         drop_lock <= 1;
         settle(4);
         drop_lock <= 0;
         chk(32'(irq), m ? 32'h0 : 32'h1, "lock loss irq");
      end
      apb(1, FCG_OFS_CTRL2, 32'h0000_0031);
      apb(1, FCG_OFS_CTRL1, 32'h0000_0078);
      apb(1, FCG_OFS_STAT1, 32'h0);
      drop_ref <= 1;
      settle(4);
      chk(32'(irq), 32'h1, "clock loss irq");
      apb(0, FCG_OFS_STAT1, 0);
      chk(32'(rd[2:0]), 32'h5, "status flags");
      drop_ref <= 0;
      apb(1, FCG_OFS_STAT1, 32'h0);
      settle(2);
      rchk(FCG_OFS_STAT1, {24'h0, 2'h3, 6'h18}, "status cleared");
      chk(32'(irq), 32'h0, "irq cleared");
      $display("event test done");
      finish_test;
   end
endmodule // fll_clock_generator_config_test
